/* shiftout_pkg.sv */
package shiftout_pkg;
	localparam int WORD_BITS = 32;
	localparam int RESULT_BITS = 24;
	localparam int SUB_BITS = 5;
	localparam int EOC_POS = 31;
	localparam int CHAN_POS = 30;
	localparam int SIGN_POS = 29;
	localparam int MSB_POS = 28;
	localparam int LSB_POS = 5;
	localparam int CLK_FREQ_HZ = 100000000;
	localparam int EXT_MIN_FREQ_HZ = 2560;
	// Absence timeout: twice the slowest detectable period, in cycles
	localparam int EXT_TIMEOUT_CYCLES = 2 * (CLK_FREQ_HZ / EXT_MIN_FREQ_HZ);
	localparam int NOTCH_DIV = 2560;
	localparam int SCK_DIV = 8;
	localparam int CONV_CYCLES = 64;
	localparam logic [23:0] RESULT_POS_CLAMP = 24'h800000;
	localparam logic [23:0] RESULT_NEG_CLAMP = 24'h7FFFFF;
	typedef enum logic [1:0] {
		ST_CONVERT = 2'h0,
		ST_SLEEP = 2'h1,
		ST_OUTPUT = 2'h3
	} phase_t;
	typedef enum logic [1:0] {
		CLK_INT_60 = 2'h0,
		CLK_INT_50 = 2'h1,
		CLK_EXT = 2'h2
	} conv_clk_t;
endpackage

/* adc_result_shiftout.sv */
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module adc_result_shiftout #(
	parameter int TIMEOUT_CYCLES = shiftout_pkg::EXT_TIMEOUT_CYCLES,
	parameter int CONV_LEN = shiftout_pkg::CONV_CYCLES,
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Sample from the filter
	input wire logic sample_valid_in,
	output logic sample_ready_out,
	input wire logic [shiftout_pkg::RESULT_BITS-1:0] sample_result_in,
	input wire logic [shiftout_pkg::SUB_BITS-1:0] sample_sub_in,
	input wire logic sample_positive_in,
	input wire logic sample_over_in,
	input wire logic sample_under_in,
	input wire logic sample_channel_in,
	// Serial link
	input wire logic chip_sel_n_in,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_out,
	output logic sdo_out,
	output logic sdo_oe_out,
	// Conversion clock selection
	input wire logic rejection_select_clock_pin_in,
	output logic ext_clock_active_out,
	output logic reject_50hz_out,
	output logic conversion_start_out,
	output logic converting_out,
	output logic [15:0] notch_divider_out
);
	import shiftout_pkg::*;

	localparam int BUF_AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	typedef struct packed {
		phase_t phase;
		logic [WORD_BITS-1:0] shift;
		logic [5:0] bit_cnt;
		logic started;
		logic int_sck;
		logic [2:0] div_cnt;
		logic [2:0] int_edges;
		logic cs_prev;
		logic sck_prev;
		logic f0_prev;
		logic [31:0] idle_cnt;
		logic ext_clk;
		logic [31:0] conv_cnt;
		logic start_pulse;
		logic sdo;
		logic sdo_oe;
		logic [BUF_AW:0] count;
		logic [BUF_AW-1:0] rd_ptr;
		logic [BUF_AW-1:0] wr_ptr;
	} state_t;

	state_t state_reg, state_next;
	logic [WORD_BITS-1:0] buf_mem [BUF_DEPTH];

	// Packs a filter sample into the output word with clamping
	function automatic logic [WORD_BITS-1:0] pack_word(input logic chan, input logic pos,
			input logic over, input logic under, input logic [23:0] res, input logic [4:0] sub);
		logic [WORD_BITS-1:0] w;
		w = '0;
		w[EOC_POS] = 1'b0;
		w[CHAN_POS] = chan;
		w[SIGN_POS] = pos;
		w[MSB_POS:LSB_POS] = res;
		w[LSB_POS-1:0] = sub;
		if (over) begin
			w[SIGN_POS] = 1'b1;
			w[MSB_POS:LSB_POS] = RESULT_POS_CLAMP;
			w[LSB_POS-1:0] = '0;
		end else if (under) begin
			w[SIGN_POS] = 1'b0;
			w[MSB_POS:LSB_POS] = RESULT_NEG_CLAMP;
			w[LSB_POS-1:0] = '1;
		end
		return w;
	endfunction

	logic buf_push;
	logic buf_pop;
	logic sck_now;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;

	assign sample_ready_out = (state_reg.count != (BUF_AW+1)'(BUF_DEPTH)) || buf_pop;
	assign buf_push = sample_valid_in && sample_ready_out;

	always_comb begin
		state_next = state_reg;
		state_next.start_pulse = 1'b0;
		buf_pop = 1'b0;
		cs_fall = state_reg.cs_prev && !chip_sel_n_in;
		state_next.cs_prev = chip_sel_n_in;
		// Mode pick at every select fall: low serial clock means external
		if (cs_fall) begin
			state_next.int_edges = sck_in ? 3'h1 : 3'h0;
		end
		// Internal mode overrides this below with the divided clock
		sck_now = sck_in;
		sck_rise = !state_reg.sck_prev && sck_now;
		sck_fall = state_reg.sck_prev && !sck_now;
		state_next.sck_prev = sck_now;

		// External conversion clock detect
		state_next.f0_prev = rejection_select_clock_pin_in;
		if (state_reg.f0_prev != rejection_select_clock_pin_in) begin
			if (state_reg.idle_cnt < 32'(TIMEOUT_CYCLES)) begin
				state_next.ext_clk = 1'b1;
			end
			state_next.idle_cnt = '0;
		end else if (state_reg.idle_cnt >= 32'(TIMEOUT_CYCLES)) begin
			state_next.ext_clk = 1'b0;
		end else begin
			state_next.idle_cnt = state_reg.idle_cnt + 32'd1;
		end

		unique case (state_reg.phase)
			ST_CONVERT: begin
				// No word in progress sees a clock source change: conv_cnt counts CONV_LEN cycles either way
				if (state_reg.conv_cnt >= 32'(CONV_LEN) && state_reg.count != '0) begin
					state_next.shift = buf_mem[state_reg.rd_ptr];
					buf_pop = 1'b1;
					state_next.rd_ptr = BUF_AW'(state_reg.rd_ptr + 1'b1);
					state_next.phase = ST_SLEEP;
				end else if (state_reg.conv_cnt < 32'(CONV_LEN)) begin
					state_next.conv_cnt = state_reg.conv_cnt + 32'd1;
				end
			end
			ST_SLEEP: begin
				// Level, not edge: a select held low through the conversion still reads
				if (!chip_sel_n_in) begin
					state_next.phase = ST_OUTPUT;
					state_next.started = 1'b0;
					state_next.bit_cnt = '0;
					state_next.int_sck = 1'b0;
					state_next.div_cnt = '0;
				end
			end
			ST_OUTPUT: begin
				if (chip_sel_n_in) begin
					if (state_reg.started) begin
						state_next.phase = ST_CONVERT;
						state_next.conv_cnt = '0;
						state_next.start_pulse = 1'b1;
					end else begin
						state_next.phase = ST_SLEEP;
					end
				end else begin
					if (state_reg.int_edges[0]) begin
						state_next.div_cnt = state_reg.div_cnt + 3'h1;
						if (state_reg.div_cnt == 3'(SCK_DIV / 2 - 1)) begin
							state_next.int_sck = !state_reg.int_sck;
							state_next.div_cnt = '0;
						end
						sck_now = state_reg.int_sck;
						sck_rise = !state_reg.sck_prev && sck_now;
						sck_fall = state_reg.sck_prev && !sck_now;
						state_next.sck_prev = sck_now;
					end
					if (sck_rise) begin
						state_next.started = 1'b1;
					end
					if (sck_fall && state_reg.started) begin
						state_next.shift = {state_reg.shift[WORD_BITS-2:0], 1'b1};
						state_next.bit_cnt = state_reg.bit_cnt + 6'h1;
						if (state_reg.bit_cnt == 6'(WORD_BITS - 1)) begin
							state_next.phase = ST_CONVERT;
							state_next.conv_cnt = '0;
							state_next.start_pulse = 1'b1;
						end
					end
				end
			end
			default: state_next.phase = ST_CONVERT;
		endcase

		if (buf_push) begin
			state_next.wr_ptr = BUF_AW'(state_reg.wr_ptr + 1'b1);
		end
		state_next.count = state_reg.count + (BUF_AW+1)'(buf_push) - (BUF_AW+1)'(buf_pop);

		state_next.sdo_oe = !chip_sel_n_in;
		if (state_next.phase == ST_OUTPUT && state_next.started) begin
			state_next.sdo = state_next.shift[WORD_BITS-1];
		end else begin
			state_next.sdo = (state_next.phase == ST_CONVERT);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			state_reg <= '0;
			state_reg.phase <= ST_CONVERT;
			state_reg.cs_prev <= 1'b1;
			state_reg.sdo <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (buf_push) begin
			buf_mem[state_reg.wr_ptr] <= pack_word(sample_channel_in, sample_positive_in,
				sample_over_in, sample_under_in, sample_result_in, sample_sub_in);
		end
	end

	assign sdo_out = state_reg.sdo;
	assign sdo_oe_out = state_reg.sdo_oe;
	assign sck_out = state_reg.int_sck;
	assign sck_oe_out = (state_reg.phase == ST_OUTPUT) && state_reg.int_edges[0] && !chip_sel_n_in;
	assign ext_clock_active_out = state_reg.ext_clk;
	assign reject_50hz_out = !state_reg.ext_clk && state_reg.f0_prev;
	assign notch_divider_out = state_reg.ext_clk ? 16'(NOTCH_DIV) : 16'h0000;
	assign conversion_start_out = state_reg.start_pulse;
	assign converting_out = (state_reg.phase == ST_CONVERT);
endmodule // adc_result_shiftout
`default_nettype wire

/* shiftout_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module shiftout_checker #(
	parameter int TIMEOUT_CYCLES = 50
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// Watched pins
	input wire logic chip_sel_n_in,
	input wire logic rejection_select_clock_pin_in,
	input wire logic sdo_out,
	input wire logic sdo_oe_out,
	input wire logic converting_out,
	input wire logic conversion_start_out,
	input wire logic ext_clock_active_out,
	input wire logic reject_50hz_out,
	input wire logic [15:0] notch_divider_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	int quiet_reg;
	// Cycles since the select pin last moved
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || $changed(rejection_select_clock_pin_in)) quiet_reg <= 0;
		else if (quiet_reg < 1000000) quiet_reg <= quiet_reg + 1;
	end
	sdo_driven_a: assert property (!chip_sel_n_in |=> sdo_oe_out)
		else $error("sdo not driven");
	sdo_released_a: assert property (chip_sel_n_in |=> !sdo_oe_out)
		else $error("sdo not released");
	busy_flag_a: assert property (converting_out && !chip_sel_n_in ##1 converting_out |-> sdo_out)
		else $error("flag low while busy");
	conv_min_len_a: assert property ($rose(converting_out) |-> converting_out [*8])
		else $error("conversion cut short");
	start_begins_a: assert property (conversion_start_out |-> ##[0:1] converting_out)
		else $error("start without conversion");
	notch_value_a: assert property (notch_divider_out == (ext_clock_active_out ? 16'hA00 : 16'h0))
		else $error("notch divider wrong");
	line_select_a: assert property (
		(!ext_clock_active_out && $stable(rejection_select_clock_pin_in)) [*4]
		|-> reject_50hz_out == rejection_select_clock_pin_in) else $error("line select wrong");
	edge_keeps_ext_a: assert property (
		ext_clock_active_out && $changed(rejection_select_clock_pin_in)
		|=> ext_clock_active_out) else $error("edge lost external clock");
	ext_fallback_a: assert property (quiet_reg > TIMEOUT_CYCLES + 4 |-> !ext_clock_active_out)
		else $error("no fallback to internal clock");
endmodule // shiftout_checker
bind adc_result_shiftout shiftout_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_shiftout_checker (
	.core_clk_in, .resetn_in, .chip_sel_n_in, .rejection_select_clock_pin_in, .sdo_out,
	.sdo_oe_out, .converting_out, .conversion_start_out, .ext_clock_active_out,
	.reject_50hz_out, .notch_divider_out);
`default_nettype wire

/* spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	// Pacing clock
	input wire logic clk_in,
	// Serial link
	input wire logic sdo_in,
	input wire logic sck_in,
	output logic chip_sel_n_out,
	output logic sck_out
);
	initial begin
		chip_sel_n_out = 1'b1;
		sck_out = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask
	// Clock level at select picks the mode: low external, high internal
	task automatic select(input logic sck_high = 1'b0);
		sck_out = sck_high;
		chip_sel_n_out = 1'b0;
		half();
		sck_out = 1'b0;
	endtask
	// Internal mode: sample on the device's own clock rises
	task automatic listen(output logic [31:0] w);
		w = 32'h0;
		repeat (32) begin
			@(posedge sck_in);
			@(negedge clk_in);
			w = {w[30:0], sdo_in};
		end
	endtask
	task automatic deselect();
		chip_sel_n_out = 1'b1;
		half();
	endtask
	// Sample on the rise, device moves on after the fall
	task automatic shift(input int n, output logic [31:0] w);
		w = 32'h0;
		repeat (n) begin
			w = {w[30:0], sdo_in};
			sck_out = 1'b1;
			half();
			sck_out = 1'b0;
			half();
		end
	endtask
endmodule // spi_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import shiftout_pkg::*;
	logic core_clk_in = 1'b0, resetn_in = 1'b0, sample_valid_in = 1'b0, host_sck;
	logic sample_positive_in = 1'b0, sample_over_in = 1'b0, sample_under_in = 1'b0;
	logic sample_channel_in = 1'b0, rejection_select_clock_pin_in = 1'b0;
	logic [23:0] sample_result_in = 24'h0;
	logic [4:0] sample_sub_in = 5'h0;
	logic chip_sel_n_in, sck_in, sck_out, sck_oe_out, sample_ready_out, sdo_out, sdo_oe_out;
	logic ext_clock_active_out, reject_50hz_out, conversion_start_out, converting_out;
	logic [15:0] notch_divider_out;
	logic [31:0] junk;
	logic [32:0] s [3] = '{{1'b1, 3'b000, 24'h5A5A5A, 5'h13}, {1'b1, 3'b101, 24'h00000F, 5'h07},
		{1'b0, 3'b010, 24'hFFF000, 5'h02}};
	int failures = 0, n_checks = 0;
	assign sck_in = (sck_oe_out === 1'b1) ? sck_out : host_sck;
	adc_result_shiftout #(.TIMEOUT_CYCLES(50), .CONV_LEN(16)) i_adc_result_shiftout (
		.core_clk_in, .resetn_in, .sample_valid_in, .sample_ready_out, .sample_result_in,
		.sample_sub_in, .sample_positive_in, .sample_over_in, .sample_under_in,
		.sample_channel_in, .chip_sel_n_in, .sck_in, .sck_out, .sck_oe_out, .sdo_out,
		.sdo_oe_out, .rejection_select_clock_pin_in, .ext_clock_active_out,
		.reject_50hz_out, .conversion_start_out, .converting_out, .notch_divider_out);
	spi_host_model i_spi_host_model (.clk_in(core_clk_in), .sdo_in(sdo_out), .sck_in(sck_in),
		.chip_sel_n_out(chip_sel_n_in), .sck_out(host_sck));
	function automatic logic [31:0] word_of(input logic [32:0] v);
		logic [31:0] w;
		w = {1'b0, v[29], v[32], v[28:0]};
		if (v[31]) w[29:0] = {1'b1, RESULT_POS_CLAMP, 5'h00};
		if (v[30]) w[29:0] = {1'b0, RESULT_NEG_CLAMP, 5'h1F};
		return w;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic push(input logic [32:0] v);
		@(negedge core_clk_in);
		{sample_positive_in, sample_over_in, sample_under_in, sample_channel_in,
			sample_result_in, sample_sub_in} = v;
		sample_valid_in = 1'b1;
		for (int i = 0; i < 400 && sample_ready_out !== 1'b1; i++) @(negedge core_clk_in);
		@(negedge core_clk_in);
		sample_valid_in = 1'b0;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 400 && converting_out !== 1'b0; i++) @(negedge core_clk_in);
	endtask
	task automatic read(input logic [31:0] exp, input logic early);
		if (!early) wait_idle();
		i_spi_host_model.select();
		check(sdo_out, early);
		if (early) wait_idle();
		repeat (2) @(negedge core_clk_in);
		check(sdo_out, 1'b0);
		i_spi_host_model.shift(32, junk);
		check(junk, exp);
		check({sdo_out, converting_out}, 2'b11);
		i_spi_host_model.deselect();
	endtask
	initial forever #5 core_clk_in = ~core_clk_in;
	initial begin
		repeat (2) @(negedge core_clk_in);
		resetn_in = 1'b1;
		check(reject_50hz_out, 1'b0);
		push(s[0]);
		push(s[1]);
		check(sample_ready_out, 1'b0);
		push(s[2]);
		i_spi_host_model.shift(4, junk);
		check(sdo_oe_out, 1'b0);
		read(word_of(s[0]), 1'b0);
		read(word_of(s[1]), 1'b1);
		wait_idle();
		i_spi_host_model.select();
		i_spi_host_model.deselect();
		read(word_of(s[2]), 1'b0);
		push(s[0]);
		wait_idle();
		i_spi_host_model.select(1'b1);
		check(sck_oe_out, 1'b1);
		i_spi_host_model.listen(junk);
		check(junk, word_of(s[0]));
		repeat (8) @(negedge core_clk_in);
		check({sdo_out, converting_out, sck_oe_out}, 3'b110);
		i_spi_host_model.deselect();
		rejection_select_clock_pin_in = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check({reject_50hz_out, ext_clock_active_out, notch_divider_out}, 18'h20000);
		repeat (40) begin
			@(negedge core_clk_in);
			rejection_select_clock_pin_in = ~rejection_select_clock_pin_in;
		end
		check({ext_clock_active_out, notch_divider_out}, 17'h10A00);
		repeat (70) @(negedge core_clk_in);
		check(ext_clock_active_out, 1'b0);
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge core_clk_in);
		failures++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
